// *** rtl/adc_sequencer_control.sv ***
// Purpose: Control of a 12-bit converter: registers, start protocol, timing, pin enables
// Assumes: Converter core returns a 12-bit sample when told to latch
// Notes:   Register reads answer one cycle after the strobe
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defines.svh"
module adc_sequencer_control
  import adc_ctl_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_B,
  input  wire logic [2:0]          I_ADDR,
  input  wire logic [7:0]          I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  output logic      [7:0]          O_RDATA,
  input  wire logic [11:0]         I_SAMPLE,
  input  wire logic [NUM_PINS-1:0] I_PORT_DIR_INPUT,
  input  wire logic [NUM_PINS-1:0] I_PORT_PULL_EN,
  output logic                     O_CONV_RESET,
  output logic                     O_CONV_CLK_EN,
  output logic                     O_POWER_DOWN,
  output logic                     O_REF_EXTERNAL,
  output logic                     O_REF_PIN_CLAIM,
  output logic                     O_BANDGAP_ROUTE,
  output logic                     O_BANDGAP_EN,
  output logic                     O_EXT_CHANNEL_EN,
  output logic      [3:0]          O_CHANNEL,
  output logic      [NUM_PINS-1:0] O_PIN_ANALOG,
  output logic      [NUM_PINS-1:0] O_PIN_DIGITAL_EN,
  output logic      [NUM_PINS-1:0] O_PIN_DIR_INPUT,
  output logic      [NUM_PINS-1:0] O_PIN_PULL_EN,
  output logic                     O_IRQ
);
  // ==========================================================
  // Parameter check
  if (NUM_PINS < 1 || NUM_PINS > 16) begin : g_bad_pins
    $error("NUM_PINS must be 1 to 16");
  end

  // ==========================================================
  // Registers
  // Reset images of the control bytes, so single bits can be picked out
  localparam logic [7:0] CTRL0_RST = `RST_CTRL_ZERO;
  localparam logic [7:0] CTRL1_RST = `RST_CTRL_ONE;
  logic        start_bit;
  logic        power_down;
  logic        align_right;
  logic [3:0]  channel_select;
  logic        bandgap_input_select;
  logic        bandgap_en;
  logic        ref_source_select;
  logic [2:0]  conv_clock_divider;
  logic [7:0]  analog_pin_enable_low;
  logic [7:0]  analog_pin_enable_high;
  logic        irq_flag;
  logic        converter_irq_enable;
  logic        global_irq_enable;
  logic [11:0] result;
  logic        start_prev;
  logic [4:0]  period_cnt;
  conv_state_t state;
  conv_state_t next_state;

  // ==========================================================
  // Decode
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        wr_pin_lo;
  logic        wr_pin_hi;
  logic        wr_irq;
  logic        next_start;
  logic        start_rise;
  logic        start_fall;
  logic        conv_tick;
  logic        conv_done;
  logic [15:0] pin_enables;
  logic [7:0]  result_low_byte;
  logic [7:0]  result_high_byte;
  logic [7:0]  ctrl0_rd;
  logic [7:0]  ctrl1_rd;
  logic [7:0]  irq_rd;
  logic [7:0]  next_rdata;

  assign wr_ctrl0  = I_WR && (I_ADDR == `OFS_CTRL_ZERO);
  assign wr_ctrl1  = I_WR && (I_ADDR == `OFS_CTRL_ONE);
  assign wr_pin_lo = I_WR && (I_ADDR == `OFS_PIN_EN_LOW);
  assign wr_pin_hi = I_WR && (I_ADDR == `OFS_PIN_EN_HIGH);
  assign wr_irq    = I_WR && (I_ADDR == `OFS_IRQ_CTRL);

  assign next_start = wr_ctrl0 ? I_WDATA[`BIT_START] : start_bit;
  assign start_rise = start_bit && !start_prev;
  assign start_fall = !start_bit && start_prev;
  // A start in the last period aborts, so it must not raise the request
  assign conv_done  = (state == ST_CONV) && conv_tick && !start_bit
                      && (period_cnt == `CONV_PERIODS - 5'h01);

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_rise)
          next_state = ST_RESET;
      end
      ST_RESET: begin
        if (start_fall)
          next_state = ST_CONV;
      end
      ST_CONV: begin
        if (start_bit)
          next_state = ST_RESET;
        else if (conv_done)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state      <= ST_IDLE;
      start_prev <= 1'b0;
      period_cnt <= 5'h00;
    end else begin
      state      <= next_state;
      start_prev <= start_bit;
      if (state != ST_CONV)
        period_cnt <= 5'h00;
      else if (conv_tick)
        period_cnt <= period_cnt + 5'h01;
    end
  end

  adc_clk_div u_div (
    .i_clk     (I_REF_CLK),
    .i_rst_b   (I_RST_B),
    .i_restart (state != ST_CONV),
    .i_code    (conv_clock_divider),
    .o_tick    (conv_tick)
  );

  // ==========================================================
  // Control registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      start_bit      <= CTRL0_RST[`BIT_START];
      power_down     <= CTRL0_RST[`BIT_POWER_DOWN];
      align_right    <= CTRL0_RST[`BIT_ALIGN];
      channel_select <= CTRL0_RST[3:0];
    end else if (wr_ctrl0) begin
      start_bit      <= next_start;
      power_down     <= I_WDATA[`BIT_POWER_DOWN];
      align_right    <= I_WDATA[`BIT_ALIGN];
      channel_select <= I_WDATA[3:0];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      bandgap_input_select <= CTRL1_RST[`BIT_BANDGAP_SEL];
      bandgap_en           <= CTRL1_RST[`BIT_BANDGAP_EN];
      ref_source_select    <= CTRL1_RST[`BIT_REF_SEL];
      conv_clock_divider   <= CTRL1_RST[2:0];
    end else if (wr_ctrl1) begin
      bandgap_input_select <= I_WDATA[`BIT_BANDGAP_SEL];
      bandgap_en           <= I_WDATA[`BIT_BANDGAP_EN];
      ref_source_select    <= I_WDATA[`BIT_REF_SEL];
      conv_clock_divider   <= I_WDATA[2:0];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      analog_pin_enable_low  <= `RST_PIN_EN;
      analog_pin_enable_high <= `RST_PIN_EN;
    end else begin
      if (wr_pin_lo)
        analog_pin_enable_low <= I_WDATA;
      if (wr_pin_hi)
        analog_pin_enable_high <= I_WDATA;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_flag             <= 1'b0;
      converter_irq_enable <= 1'b0;
      global_irq_enable    <= 1'b0;
    end else begin
      if (conv_done)
        irq_flag <= 1'b1;
      else if (wr_irq)
        irq_flag <= I_WDATA[`BIT_IRQ_FLAG];
      if (wr_irq) begin
        converter_irq_enable <= I_WDATA[`BIT_IRQ_EN];
        global_irq_enable    <= I_WDATA[`BIT_GLOBAL_EN];
      end
    end
  end

  // Both bytes come from one capture so a read never mixes two samples
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B)
      result <= 12'h000;
    else if (conv_done)
      result <= I_SAMPLE;
  end

  // ==========================================================
  // Read path
  assign result_high_byte = align_right ? {4'h0, result[11:8]}
                                        : result[11:4];
  assign result_low_byte  = align_right ? result[7:0]
                                        : {result[3:0], 4'h0};
  assign ctrl0_rd = {start_bit, ((state != ST_IDLE) || start_bit), power_down,
                     align_right, channel_select};
  assign ctrl1_rd = {bandgap_input_select, bandgap_en, 1'b0, ref_source_select,
                     1'b0, conv_clock_divider};
  assign irq_rd   = {5'h00, global_irq_enable, converter_irq_enable, irq_flag};

  always_comb begin
    next_rdata = 8'h00;
    unique case (I_ADDR)
      `OFS_RESULT_LOW:  next_rdata = result_low_byte;
      `OFS_RESULT_HIGH: next_rdata = result_high_byte;
      `OFS_CTRL_ZERO:   next_rdata = ctrl0_rd;
      `OFS_CTRL_ONE:    next_rdata = ctrl1_rd;
      `OFS_PIN_EN_LOW:  next_rdata = analog_pin_enable_low;
      `OFS_PIN_EN_HIGH: next_rdata = analog_pin_enable_high;
      `OFS_IRQ_CTRL:    next_rdata = irq_rd;
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B)
      O_RDATA <= 8'h00;
    else if (I_RD)
      O_RDATA <= next_rdata;
    else
      O_RDATA <= 8'h00;
  end

  // ==========================================================
  // Converter and pin outputs
  // Start high resets the core at once, a cycle before the state follows
  assign O_CONV_RESET     = (state != ST_CONV) || start_bit;
  assign O_CONV_CLK_EN    = (state == ST_CONV) && conv_tick && !start_bit;
  assign O_POWER_DOWN     = power_down;
  assign O_REF_EXTERNAL   = ref_source_select;
  assign O_REF_PIN_CLAIM  = ref_source_select;
  assign O_BANDGAP_ROUTE  = bandgap_input_select;
  assign O_BANDGAP_EN     = bandgap_en;
  assign O_EXT_CHANNEL_EN = !bandgap_input_select;
  assign O_CHANNEL        = channel_select;
  assign O_IRQ            = irq_flag && converter_irq_enable && global_irq_enable;

  assign pin_enables = {analog_pin_enable_high, analog_pin_enable_low};

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    adc_pin_mux u_pin (
      .i_analog_en  (pin_enables[p]),
      .i_dir_input  (I_PORT_DIR_INPUT[p]),
      .i_pull_en    (I_PORT_PULL_EN[p]),
      .o_analog_sel (O_PIN_ANALOG[p]),
      .o_digital_en (O_PIN_DIGITAL_EN[p]),
      .o_dir_input  (O_PIN_DIR_INPUT[p]),
      .o_pull_en    (O_PIN_PULL_EN[p])
    );
  end
endmodule : adc_sequencer_control
`default_nettype wire

// *** rtl/adc_ctl_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the converter control
// Assumes: One 25 MHz clock; byte-wide registers on a plain strobe port
// Notes:   Summary of operation sits below
//
// Summary of operation
// - Reference select high picks external reference pin
// - Divider code 000..110 gives divide 1..64
// - Set pin enable makes that pin analog input
// - All pin enables reset to one
// - Conversion starts on start bit high-then-low
// - Start held high keeps converter reset, pending set
// - Hardware clears pending flag at conversion end
// - Conversion end sets request; enabled raises interrupt
// - Conversion lasts sixteen converter clock periods
// - Reference select claims shared pin, disables others
// - Analog pin drops pull-high and other functions
// - Analog enable overrides port direction setting
// - Result is twelve bits, full scale fff
// - Align bit zero left-justifies, one right-justifies
// - Unused result bits read as zero
// - Bandgap select routes bandgap, drops external channels
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFS_RESULT_LOW      3'h0
`define OFS_RESULT_HIGH     3'h1
`define OFS_CTRL_ZERO       3'h2
`define OFS_CTRL_ONE        3'h3
`define OFS_PIN_EN_LOW      3'h4
`define OFS_PIN_EN_HIGH     3'h5
`define OFS_IRQ_CTRL        3'h6

// ==========================================================
// Field positions
`define BIT_START           7
`define BIT_PENDING         6
`define BIT_POWER_DOWN      5
`define BIT_ALIGN           4
`define BIT_BANDGAP_SEL     7
`define BIT_BANDGAP_EN      6
`define BIT_REF_SEL         4
`define BIT_IRQ_FLAG        0
`define BIT_IRQ_EN          1
`define BIT_GLOBAL_EN       2

// ==========================================================
// Reset values
`define RST_CTRL_ZERO       8'h60
`define RST_CTRL_ONE        8'h00
`define RST_PIN_EN          8'hff

// ==========================================================
// Timing
`define CONV_PERIODS        5'h10
`define DIV_CODE_MAX        3'h6

`endif

// *** rtl/adc_ctl_pkg.sv ***
// Purpose: Types of the converter control
// Assumes: Constants live in the defines header
// Notes:   One-hot state codes
package adc_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RESET = 3'b010,
    ST_CONV  = 3'b100
  } conv_state_t;
endpackage : adc_ctl_pkg

// *** rtl/adc_clk_div.sv ***
// Purpose: Converter clock enable from the system clock
// Assumes: Code 111 never written by software
// Notes:   Restart aligns the first period to the conversion start
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defines.svh"
module adc_clk_div (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_restart,
  input  wire logic [2:0] i_code,
  output logic            o_tick
);
  logic [5:0] cnt;
  logic [5:0] limit;
  // ==========================================================
  // Divide select
  assign limit  = 6'((7'h01 << i_code) - 7'h01);
  assign o_tick = (cnt >= limit) && !i_restart;   // 111 falls back to 64

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      cnt <= 6'h00;
    else if (i_restart || o_tick)
      cnt <= 6'h00;
    else
      cnt <= cnt + 6'h01;
  end
endmodule : adc_clk_div
`default_nettype wire

// *** rtl/adc_pin_mux.sv ***
// Purpose: Per-pin function control from the analog enables
// Assumes: Port logic outside takes these overrides
// Notes:   One instance per shared pin
`timescale 1ns/1ps
`default_nettype none
module adc_pin_mux (
  input  wire logic i_analog_en,
  input  wire logic i_dir_input,
  input  wire logic i_pull_en,
  output logic      o_analog_sel,
  output logic      o_digital_en,
  output logic      o_dir_input,
  output logic      o_pull_en
);
  // ==========================================================
  // Pin override
  assign o_analog_sel = i_analog_en;
  assign o_digital_en = !i_analog_en;
  assign o_pull_en    = i_pull_en && !i_analog_en;
  assign o_dir_input  = i_dir_input || i_analog_en;
endmodule : adc_pin_mux
`default_nettype wire

// *** verif/adc_core_model.sv ***
// Purpose: Behavioural converter core behind the sequencer
// Assumes: Sample is valid only after the first tick of a run
// Notes:   Output churns while held in reset or powered down
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_conv_reset,
  input  wire logic        i_power_down,
  input  wire logic        i_clk_en,
  input  wire logic [11:0] i_value,
  output logic      [11:0] o_sample
);
  // Churning output so a stale capture never looks right by luck
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sample <= 12'h5a5;
    end else if (i_conv_reset || i_power_down) begin
      o_sample <= ~o_sample;
    end else if (i_clk_en) begin
      o_sample <= i_value;
    end
  end
endmodule : adc_core_model
`default_nettype wire

// *** verif/adc_seq_monitor.sv ***
// Purpose: Port checks of the converter control
// Assumes: Sees top module ports only
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defines.svh"
module adc_seq_monitor #(
  parameter int NUM_PINS = 16
) (
  input wire logic                I_REF_CLK,
  input wire logic                I_RST_B,
  input wire logic [2:0]          I_ADDR,
  input wire logic [7:0]          I_WDATA,
  input wire logic                I_WR,
  input wire logic                I_RD,
  input wire logic [7:0]          O_RDATA,
  input wire logic [NUM_PINS-1:0] I_PORT_DIR_INPUT,
  input wire logic [NUM_PINS-1:0] I_PORT_PULL_EN,
  input wire logic                O_CONV_RESET,
  input wire logic                O_CONV_CLK_EN,
  input wire logic                O_REF_EXTERNAL,
  input wire logic                O_REF_PIN_CLAIM,
  input wire logic                O_BANDGAP_ROUTE,
  input wire logic                O_EXT_CHANNEL_EN,
  input wire logic [NUM_PINS-1:0] O_PIN_ANALOG,
  input wire logic [NUM_PINS-1:0] O_PIN_DIGITAL_EN,
  input wire logic [NUM_PINS-1:0] O_PIN_DIR_INPUT,
  input wire logic [NUM_PINS-1:0] O_PIN_PULL_EN
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  // ==========================================================
  // Helpers
  wire logic start_wr = I_WR && I_ADDR == `OFS_CTRL_ZERO && I_WDATA[`BIT_START];
  logic [4:0] ticks;
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ticks <= 5'h00;
    end else if (O_CONV_RESET) begin
      ticks <= 5'h00;
    end else if (O_CONV_CLK_EN) begin
      ticks <= ticks + 5'h01;
    end
  end
  sequence s_start_wr;
    start_wr;
  endsequence
  // Abort excluded: an aborted run ends early on purpose
  sequence s_conv_end;
    $rose(O_CONV_RESET) && !$past(start_wr);
  endsequence
  // ==========================================================
  // Assertions
  a_idle_rdata_zero: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data not zero outside read slot");
  a_start_holds_reset: assert property (s_start_wr |=> O_CONV_RESET [*2])
    else $error("start write did not hold converter reset");
  a_pending_while_conv: assert property (
    I_RD && I_ADDR == `OFS_CTRL_ZERO && !O_CONV_RESET |=> O_RDATA[`BIT_PENDING])
    else $error("pending flag low during conversion");
  a_sixteen_ticks: assert property (s_conv_end |-> ticks == 5'h10)
    else $error("conversion length not sixteen ticks");
  a_tick_in_conv: assert property (O_CONV_CLK_EN |-> !O_CONV_RESET)
    else $error("converter tick outside conversion");
  a_pin_analog_map: assert property (O_PIN_DIGITAL_EN == ~O_PIN_ANALOG)
    else $error("digital enable not inverse of analog");
  a_pull_dropped: assert property (
    O_PIN_PULL_EN == (I_PORT_PULL_EN & ~O_PIN_ANALOG))
    else $error("pull-high kept on analog pin");
  a_dir_override: assert property (
    O_PIN_DIR_INPUT == (I_PORT_DIR_INPUT | O_PIN_ANALOG))
    else $error("analog pin not forced to input");
  a_ref_pin_claim: assert property (O_REF_PIN_CLAIM == O_REF_EXTERNAL)
    else $error("reference pin claim mismatch");
  a_bandgap_drops: assert property (O_EXT_CHANNEL_EN == !O_BANDGAP_ROUTE)
    else $error("external channels not dropped for bandgap");
endmodule : adc_seq_monitor
bind adc_sequencer_control adc_seq_monitor #(.NUM_PINS(NUM_PINS)) adc_seq_monitor_inst (
  .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PORT_DIR_INPUT(I_PORT_DIR_INPUT),
  .I_PORT_PULL_EN(I_PORT_PULL_EN), .O_CONV_RESET(O_CONV_RESET),
  .O_CONV_CLK_EN(O_CONV_CLK_EN), .O_REF_EXTERNAL(O_REF_EXTERNAL),
  .O_REF_PIN_CLAIM(O_REF_PIN_CLAIM), .O_BANDGAP_ROUTE(O_BANDGAP_ROUTE),
  .O_EXT_CHANNEL_EN(O_EXT_CHANNEL_EN), .O_PIN_ANALOG(O_PIN_ANALOG),
  .O_PIN_DIGITAL_EN(O_PIN_DIGITAL_EN), .O_PIN_DIR_INPUT(O_PIN_DIR_INPUT),
  .O_PIN_PULL_EN(O_PIN_PULL_EN));
`default_nettype wire

// *** verif/test_adc_sequencer_control.sv ***
// Purpose: Self-checking bench of the converter control
// Assumes: 25 MHz clock, read data one cycle after the strobe
// Notes:   Reads are queued and compared by a watcher process
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defines.svh"
module test_adc_sequencer_control;
  logic        I_REF_CLK = 1'b0;
  logic        I_RST_B = 1'b0;
  logic [2:0]  I_ADDR = 3'h0;
  logic [7:0]  I_WDATA = 8'h00;
  logic        I_WR = 1'b0;
  logic        I_RD = 1'b0;
  logic [15:0] I_PORT_DIR_INPUT = 16'h0000;
  logic [15:0] I_PORT_PULL_EN = 16'h0000;
  logic [11:0] sample_val = 12'h000;
  logic [11:0] I_SAMPLE;
  logic [7:0]  O_RDATA;
  logic        O_CONV_RESET, O_CONV_CLK_EN, O_POWER_DOWN, O_REF_EXTERNAL, O_REF_PIN_CLAIM;
  logic        O_BANDGAP_ROUTE, O_BANDGAP_EN, O_EXT_CHANNEL_EN, O_IRQ;
  logic [3:0]  O_CHANNEL;
  logic [15:0] O_PIN_ANALOG, O_PIN_DIGITAL_EN, O_PIN_DIR_INPUT, O_PIN_PULL_EN;
  logic [7:0]  exp_q[$];
  logic        rd_seen = 1'b0;
  logic        al;
  logic [15:0] pins;
  logic [7:0]  v;
  int          err_total = 0;
  int          tests_run = 0;
  int          seed = 92;
  int          i;
  // Settling time after power-up is not given; a plain default
  localparam int SETTLE_CYCLES = 8;
  always #20 I_REF_CLK = ~I_REF_CLK;
  adc_sequencer_control #(.NUM_PINS(16)) adc_sequencer_control_inst (
    .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SAMPLE(I_SAMPLE),
    .I_PORT_DIR_INPUT(I_PORT_DIR_INPUT), .I_PORT_PULL_EN(I_PORT_PULL_EN),
    .O_CONV_RESET(O_CONV_RESET), .O_CONV_CLK_EN(O_CONV_CLK_EN), .O_POWER_DOWN(O_POWER_DOWN),
    .O_REF_EXTERNAL(O_REF_EXTERNAL), .O_REF_PIN_CLAIM(O_REF_PIN_CLAIM),
    .O_BANDGAP_ROUTE(O_BANDGAP_ROUTE), .O_BANDGAP_EN(O_BANDGAP_EN),
    .O_EXT_CHANNEL_EN(O_EXT_CHANNEL_EN), .O_CHANNEL(O_CHANNEL), .O_PIN_ANALOG(O_PIN_ANALOG),
    .O_PIN_DIGITAL_EN(O_PIN_DIGITAL_EN), .O_PIN_DIR_INPUT(O_PIN_DIR_INPUT),
    .O_PIN_PULL_EN(O_PIN_PULL_EN), .O_IRQ(O_IRQ));
  adc_core_model adc_core_model_inst (
    .i_clk(I_REF_CLK), .i_rst_b(I_RST_B), .i_conv_reset(O_CONV_RESET),
    .i_power_down(O_POWER_DOWN), .i_clk_en(O_CONV_CLK_EN), .i_value(sample_val),
    .o_sample(I_SAMPLE));
  // ==========================================================
  // Checking
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Read data stands one cycle only, so the watcher samples mid-cycle
  always @(posedge I_REF_CLK) rd_seen <= I_RD;
  always @(negedge I_REF_CLK) begin
    if (rd_seen) begin
      check(O_RDATA, exp_q.pop_front());
    end
  end
  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_REF_CLK);
    I_WR <= 1'b1;
    I_RD <= 1'b0;
    I_ADDR <= a;
    I_WDATA <= d;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge I_REF_CLK);
    I_WR <= 1'b0;
    I_RD <= 1'b1;
    I_ADDR <= a;
    exp_q.push_back(e);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge I_REF_CLK);
      I_WR <= 1'b0;
      I_RD <= 1'b0;
    end
    @(negedge I_REF_CLK);
  endtask : idle
  function automatic logic [7:0] res_hi(input logic [11:0] r, input logic a);
    return a ? {4'h0, r[11:8]} : r[11:4];
  endfunction : res_hi
  function automatic logic [7:0] res_lo(input logic [11:0] r, input logic a);
    return a ? r[7:0] : {r[3:0], 4'h0};
  endfunction : res_lo
  // Start pulse from a low start bit, then tick count and spacing
  task automatic conv(input int code);
    int n, first, last, k;
    n = 0;
    first = 0;
    last = 0;
    sample_val <= 12'($random(seed));
    wr(`OFS_CTRL_ONE, {5'h00, code[2:0]});
    wr(`OFS_CTRL_ZERO, {3'b100, al, 4'h3});
    wr(`OFS_CTRL_ZERO, {3'b000, al, 4'h3});
    rd(`OFS_CTRL_ZERO, {3'b010, al, 4'h3});
    idle(1);
    for (k = 0; k < 1200 && !(n > 0 && O_CONV_RESET); k++) begin
      if (O_CONV_CLK_EN) begin
        if (n == 0) first = k;
        last = k;
        n++;
      end
      @(negedge I_REF_CLK);
    end
    if (k >= 1200) begin
      err_total++;
      end_of_test();
    end
    check(16'(n), 16'h0010);
    check(16'(last - first), 16'(15 << code));
    rd(`OFS_CTRL_ZERO, {3'b000, al, 4'h3});
    rd(`OFS_RESULT_LOW, res_lo(sample_val, al));
    rd(`OFS_RESULT_HIGH, res_hi(sample_val, al));
    rd(`OFS_IRQ_CTRL, 8'h07);
    idle(1);
    check(O_IRQ, 1'b1);
    check(O_CHANNEL, 4'h3);
    wr(`OFS_IRQ_CTRL, 8'h06);
    idle(1);
    check(O_IRQ, 1'b0);
  endtask : conv
  // ==========================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge I_REF_CLK);
    I_RST_B <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(3'(i), (i == 2) ? 8'h20 : (i == 4 || i == 5) ? 8'hff : 8'h00);
    end
    idle(1);
    check(O_PIN_ANALOG, 16'hffff);
    check(O_POWER_DOWN, 1'b1);
    for (i = 0; i < 6; i++) begin
      pins = (i == 0) ? 16'h0000 : 16'($random(seed));
      wr(`OFS_PIN_EN_LOW, pins[7:0]);
      I_PORT_DIR_INPUT <= 16'($random(seed));
      I_PORT_PULL_EN <= 16'($random(seed));
      wr(`OFS_PIN_EN_HIGH, pins[15:8]);
      rd(`OFS_PIN_EN_LOW, pins[7:0]);
      idle(1);
      check(O_PIN_ANALOG, pins);
      check(O_PIN_PULL_EN, I_PORT_PULL_EN & ~pins);
      check(O_PIN_DIR_INPUT, I_PORT_DIR_INPUT | pins);
    end
    for (i = 0; i < 4; i++) begin
      v = {i[1], 2'b10, i[0], 4'h0};
      wr(`OFS_CTRL_ONE, v);
      rd(`OFS_CTRL_ONE, v);
      idle(1);
      check(O_REF_EXTERNAL, i[0]);
      check(O_REF_PIN_CLAIM, i[0]);
      check(O_BANDGAP_ROUTE, i[1]);
      check(O_EXT_CHANNEL_EN, !i[1]);
      check(O_BANDGAP_EN, 1'b1);
    end
    wr(`OFS_IRQ_CTRL, 8'h06);
    wr(`OFS_CTRL_ZERO, 8'h03);
    idle(SETTLE_CYCLES);
    check(O_POWER_DOWN, 1'b0);
    // Codes below 4 run faster than the recommended period at 25 MHz,
    // kept only to cover the divider
    for (i = 0; i <= `DIV_CODE_MAX; i++) begin
      al = i[0];
      conv(i);
    end
    // Abort mid-run: result kept, no request raised
    wr(`OFS_CTRL_ZERO, {3'b100, al, 4'h3});
    wr(`OFS_CTRL_ZERO, {3'b000, al, 4'h3});
    idle(20);
    rd(`OFS_CTRL_ZERO, {3'b010, al, 4'h3});
    idle(20);
    wr(`OFS_CTRL_ZERO, {3'b100, al, 4'h3});
    rd(`OFS_CTRL_ZERO, {3'b110, al, 4'h3});
    rd(`OFS_IRQ_CTRL, 8'h06);
    rd(`OFS_RESULT_HIGH, res_hi(sample_val, al));
    idle(1);
    check(O_CONV_RESET, 1'b1);
    end_of_test();
  end
endmodule : test_adc_sequencer_control
`default_nettype wire
